// >>> pve_pkg.sv
package pve_pkg;
   typedef enum logic [1:0] {
      OP_VERIFY,
      OP_CHANGE,
      OP_DISABLE
   } pve_op_t;

   localparam int PIN_W = 64;
   localparam int DATA_W = 128;
   localparam int RETRY_W = 2;
   localparam logic [RETRY_W-1:0] RETRY_INIT = 2'h3;
   localparam logic [PIN_W-1:0] PIN_RESET = 64'hffffffffffffffff;

   localparam logic [15:0] SW_OK = 16'h9000;
   localparam logic [15:0] SW_RETRY_BASE = 16'h63c0;
   localparam logic [15:0] SW_BLOCKED = 16'h6983;
   localparam logic [15:0] SW_COND = 16'h6985;
   localparam logic [15:0] SW_BAD_P1P2 = 16'h6b00;
   localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
   localparam logic [15:0] SW_REF_NF = 16'h6a88;

   localparam logic [7:0] LC_EMPTY = 8'h00;
   localparam logic [7:0] LC_PIN = 8'h08;
   localparam logic [7:0] LC_CHANGE = 8'h10;
   localparam logic [7:0] P1_NONE = 8'h00;
   localparam logic [7:0] USAGE_USE = 8'h08;
   localparam logic [7:0] USAGE_NONE = 8'h00;

   localparam int QUAL_SEL_BIT = 7;
   localparam int QUAL_RFU_HI = 6;
   localparam int QUAL_RFU_LO = 5;
   localparam int QUAL_REF_HI = 4;

   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_QUAL = 8'h04;
   localparam logic [7:0] REG_DATA0 = 8'h08;
   localparam logic [7:0] REG_DATA1 = 8'h0c;
   localparam logic [7:0] REG_DATA2 = 8'h10;
   localparam logic [7:0] REG_DATA3 = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// >>> pve_link_if.sv
`timescale 1ns/1ps
interface pve_link_if;
   import pve_pkg::*;
   logic cmd_valid;
   logic cmd_ready;
   pve_op_t cmd_op;
   logic [7:0] cmd_p1;
   logic [7:0] cmd_p2;
   logic [7:0] cmd_lc;
   logic [DATA_W-1:0] cmd_data;
   logic rsp_valid;
   logic [15:0] rsp_sw;

   modport card (
      input cmd_valid, cmd_op, cmd_p1, cmd_p2, cmd_lc, cmd_data,
      output cmd_ready, rsp_valid, rsp_sw
   );
   modport term (
      output cmd_valid, cmd_op, cmd_p1, cmd_p2, cmd_lc, cmd_data,
      input cmd_ready, rsp_valid, rsp_sw
   );
endinterface

// >>> pve_card.sv
// Functional notes
// - Verify only when PIN enabled and unblocked.
// - Verified status shared by every logical channel.
// - PIN-guarded function refused until PIN verified.
// - Correct verify restores retry counter to three.
// - Wrong verify decrements counter on any channel.
// - Answer 63C2, 63C1, then block with 63C0.
// - Verify with data on blocked PIN: 6983.
// - Empty verify reports remaining retries as 63CX.
// - Empty verify on blocked PIN answers 63C0.
// - Qualifier: select bit, zero bits, reference 01-1F.
// - Change carries 16 bytes, old then new.
// - Correct change resets counter, installs new PIN.
// - Wrong change decrements, keeps PIN, blocks third.
// - Disable refused when disabled or blocked.
// - Correct disable resets counter, disables PIN.
// - Replacement key gets usage qualifier 08.
// - Replacement gates single-reference files; multi-reference open.
// - Successful disable triggers security environment revalidation.
// - Wrong disable decrements, stays enabled, blocks third.
// - Blocked PIN condition unsatisfiable until release.
// - Disable P1: replace bit, zero bits, key reference.
`timescale 1ns/1ps
module pve_card
   import pve_pkg::*;
#(
   parameter int NUM_PINS = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Command link from the terminal
   pve_link_if.card link,
   // Release of a blocked PIN
   input wire logic pin_release_valid,
   input wire logic [4:0] pin_release_ref,
   input wire logic [PIN_W-1:0] pin_release_value,
   // File access check
   input wire logic acc_valid,
   input wire logic [NUM_PINS-1:0] acc_mask,
   output logic acc_done_ff,
   output logic acc_grant_ff,
   // PIN state
   output logic [NUM_PINS-1:0] pin_blocked_ff,
   output logic [NUM_PINS-1:0] pin_disabled_ff,
   output logic [NUM_PINS-1:0] pin_verified_ff,
   output logic [7:0] key_usage_ff [NUM_PINS],
   output logic se_revalidate_ff
);
   localparam int IDXW = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;

   logic [PIN_W-1:0] pin_val_ff [NUM_PINS];
   logic [RETRY_W-1:0] retry_ff [NUM_PINS];
   logic [NUM_PINS-1:0] repl_on_ff;
   logic [IDXW-1:0] repl_idx_ff [NUM_PINS];
   logic cmd_ready_ff;
   logic rsp_valid_ff;
   logic [15:0] rsp_sw_ff;

   logic take;
   logic [4:0] ref_num;
   logic ref_ok;
   logic [IDXW-1:0] idx;
   logic [4:0] alt_num;
   logic alt_ok;
   logic [IDXW-1:0] alt_idx;
   logic match;
   logic [RETRY_W-1:0] cur_retry;
   logic [RETRY_W-1:0] dec_retry;
   logic do_ok;
   logic do_fail;
   logic [15:0] sw;
   logic [NUM_PINS-1:0] pin_sat;
   logic multi_ref;
   logic any_open;
   logic rel_ok;
   logic [IDXW-1:0] rel_idx;

   assign take = link.cmd_valid && cmd_ready_ff;
   assign ref_num = link.cmd_p2[QUAL_REF_HI:0];
   assign ref_ok = (link.cmd_p2[QUAL_RFU_HI:QUAL_RFU_LO] == 2'h0) && (ref_num != 5'h0)
      && (ref_num <= 5'(NUM_PINS));
   assign idx = IDXW'(ref_num - 5'h1);
   assign alt_num = link.cmd_p1[QUAL_REF_HI:0];
   assign alt_ok = (alt_num != 5'h0) && (alt_num <= 5'(NUM_PINS));
   assign alt_idx = IDXW'(alt_num - 5'h1);
   assign match = link.cmd_data[DATA_W-1 -: PIN_W] == pin_val_ff[idx];
   assign cur_retry = retry_ff[idx];
   // The blocked check comes first, so the counter is never zero here.
   assign dec_retry = cur_retry - 2'h1;
   assign rel_ok = (pin_release_ref != 5'h0) && (pin_release_ref <= 5'(NUM_PINS));
   assign rel_idx = IDXW'(pin_release_ref - 5'h1);

   always_comb begin
      do_ok = 1'b0;
      do_fail = 1'b0;
      sw = SW_OK;
      if (!ref_ok) begin
         sw = SW_REF_NF;
      end else begin
         unique case (link.cmd_op)
            OP_VERIFY: begin
               if (link.cmd_p1 != P1_NONE) begin
                  sw = SW_BAD_P1P2;
               end else if (link.cmd_lc == LC_EMPTY) begin
                  sw = SW_RETRY_BASE | 16'(cur_retry);
               end else if (link.cmd_lc != LC_PIN) begin
                  sw = SW_WRONG_LEN;
               end else if (pin_blocked_ff[idx]) begin
                  sw = SW_BLOCKED;
               end else if (pin_disabled_ff[idx]) begin
                  sw = SW_COND;
               end else if (match) begin
                  do_ok = 1'b1;
               end else begin
                  do_fail = 1'b1;
                  sw = SW_RETRY_BASE | 16'(dec_retry);
               end
            end
            OP_CHANGE: begin
               if (link.cmd_p1 != P1_NONE) begin
                  sw = SW_BAD_P1P2;
               end else if (link.cmd_lc != LC_CHANGE) begin
                  sw = SW_WRONG_LEN;
               end else if (pin_blocked_ff[idx]) begin
                  sw = SW_BLOCKED;
               end else if (pin_disabled_ff[idx]) begin
                  sw = SW_COND;
               end else if (match) begin
                  do_ok = 1'b1;
               end else begin
                  do_fail = 1'b1;
                  sw = SW_RETRY_BASE | 16'(dec_retry);
               end
            end
            OP_DISABLE: begin
               if (link.cmd_p1[QUAL_RFU_HI:QUAL_RFU_LO] != 2'h0
                   || (link.cmd_p1[QUAL_SEL_BIT] && !alt_ok)
                   || (!link.cmd_p1[QUAL_SEL_BIT] && alt_num != 5'h0)) begin
                  sw = SW_BAD_P1P2;
               end else if (link.cmd_lc != LC_PIN) begin
                  sw = SW_WRONG_LEN;
               end else if (pin_blocked_ff[idx]) begin
                  sw = SW_BLOCKED;
               end else if (pin_disabled_ff[idx]) begin
                  sw = SW_COND;
               end else if (match) begin
                  do_ok = 1'b1;
               end else begin
                  do_fail = 1'b1;
                  sw = SW_RETRY_BASE | 16'(dec_retry);
               end
            end
            default: begin
               sw = SW_BAD_P1P2;
            end
         endcase
      end
   end

   // A release on the same cycle as a command to the same PIN wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            retry_ff[i] <= RETRY_INIT;
         end
         pin_blocked_ff <= '0;
      end else begin
         if (take && do_ok) begin
            retry_ff[idx] <= RETRY_INIT;
         end else if (take && do_fail) begin
            retry_ff[idx] <= dec_retry;
            if (dec_retry == 2'h0) begin
               pin_blocked_ff[idx] <= 1'b1;
            end
         end
         if (pin_release_valid && rel_ok) begin
            retry_ff[rel_idx] <= RETRY_INIT;
            pin_blocked_ff[rel_idx] <= 1'b0;
         end
      end
   end

   // One shared flag per PIN, so a verify on any channel serves all.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_verified_ff <= '0;
      end else begin
         if (take && do_ok && link.cmd_op != OP_DISABLE) begin
            pin_verified_ff[idx] <= 1'b1;
         end else if (take && do_fail) begin
            pin_verified_ff[idx] <= 1'b0;
         end
         if (pin_release_valid && rel_ok) begin
            pin_verified_ff[rel_idx] <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            pin_val_ff[i] <= PIN_RESET;
         end
      end else begin
         if (take && do_ok && link.cmd_op == OP_CHANGE) begin
            pin_val_ff[idx] <= link.cmd_data[PIN_W-1:0];
         end
         if (pin_release_valid && rel_ok) begin
            pin_val_ff[rel_idx] <= pin_release_value;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_disabled_ff <= '0;
         repl_on_ff <= '0;
         for (int i = 0; i < NUM_PINS; i++) begin
            repl_idx_ff[i] <= '0;
            key_usage_ff[i] <= USAGE_NONE;
         end
      end else begin
         if (take && do_ok && link.cmd_op == OP_DISABLE) begin
            pin_disabled_ff[idx] <= 1'b1;
            repl_on_ff[idx] <= link.cmd_p1[QUAL_SEL_BIT];
            repl_idx_ff[idx] <= alt_idx;
            if (link.cmd_p1[QUAL_SEL_BIT]) begin
               key_usage_ff[alt_idx] <= USAGE_USE;
            end
         end
         if (pin_release_valid && rel_ok) begin
            pin_disabled_ff[rel_idx] <= 1'b0;
            repl_on_ff[rel_idx] <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         se_revalidate_ff <= 1'b0;
      end else begin
         se_revalidate_ff <= take && do_ok && link.cmd_op == OP_DISABLE;
      end
   end

   // The card answers every command one cycle after taking it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_ready_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_sw_ff <= SW_OK;
      end else begin
         cmd_ready_ff <= 1'b1;
         rsp_valid_ff <= take;
         if (take) begin
            rsp_sw_ff <= sw;
         end
      end
   end

   assign link.cmd_ready = cmd_ready_ff;
   assign link.rsp_valid = rsp_valid_ff;
   assign link.rsp_sw = rsp_sw_ff;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_sat
      assign pin_sat[i] = pin_blocked_ff[i] ? 1'b0 :
         pin_disabled_ff[i] ? (!repl_on_ff[i] || pin_verified_ff[repl_idx_ff[i]]) :
         pin_verified_ff[i];
   end
   assign multi_ref = |(acc_mask & (acc_mask - 1'b1));
   assign any_open = |(acc_mask & pin_disabled_ff & ~pin_blocked_ff);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_done_ff <= 1'b0;
         acc_grant_ff <= 1'b0;
      end else begin
         acc_done_ff <= acc_valid;
         if (acc_valid) begin
            acc_grant_ff <= (multi_ref && any_open) || (&(pin_sat | ~acc_mask));
         end
      end
   end
endmodule

// >>> pve_terminal.sv
`timescale 1ns/1ps
module pve_terminal
   import pve_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Command link to the card
   pve_link_if.term link
);
   logic aw_held_ff;
   logic [7:0] aw_addr_ff;
   logic w_held_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [31:0] qual_ff;
   logic [31:0] data_ff [4];
   logic cmd_valid_ff;
   pve_op_t op_ff;
   logic busy_ff;
   logic done_ff;
   logic [15:0] sw_ff;
   logic do_write;
   logic wr_map;
   logic [31:0] wmask;
   logic go;

   assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
   assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
   assign wr_map = aw_addr_ff <= REG_STATUS && aw_addr_ff[1:0] == 2'h0;
   // A start while a command is outstanding is dropped, not queued.
   assign go = do_write && aw_addr_ff == REG_CTRL && w_strb_ff[0] && w_data_ff[0] && !busy_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_held_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= AXI_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_ff) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_map ? AXI_OKAY : AXI_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         qual_ff <= '0;
         for (int i = 0; i < 4; i++) begin
            data_ff[i] <= '0;
         end
      end else if (do_write) begin
         if (aw_addr_ff == REG_QUAL) begin
            qual_ff <= (qual_ff & ~wmask) | (w_data_ff & wmask);
         end
         for (int i = 0; i < 4; i++) begin
            if (aw_addr_ff == REG_DATA0 + 8'(4 * i)) begin
               data_ff[i] <= (data_ff[i] & ~wmask) | (w_data_ff & wmask);
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= AXI_OKAY;
      end else if (s_axi_arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= AXI_OKAY;
         unique case (s_axi_araddr)
            REG_CTRL: rdata_ff <= {29'h0, op_ff, 1'b0};
            REG_QUAL: rdata_ff <= {8'h0, qual_ff[23:0]};
            REG_DATA0: rdata_ff <= data_ff[0];
            REG_DATA1: rdata_ff <= data_ff[1];
            REG_DATA2: rdata_ff <= data_ff[2];
            REG_DATA3: rdata_ff <= data_ff[3];
            REG_STATUS: rdata_ff <= {sw_ff, 14'h0, done_ff, busy_ff};
            default: begin
               rdata_ff <= '0;
               rresp_ff <= AXI_SLVERR;
            end
         endcase
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_valid_ff <= 1'b0;
         op_ff <= OP_VERIFY;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         sw_ff <= '0;
      end else begin
         if (go) begin
            cmd_valid_ff <= 1'b1;
            op_ff <= pve_op_t'(w_data_ff[2:1]);
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
         end else if (cmd_valid_ff && link.cmd_ready) begin
            cmd_valid_ff <= 1'b0;
         end
         if (busy_ff && !cmd_valid_ff && link.rsp_valid) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            sw_ff <= link.rsp_sw;
         end
      end
   end

   assign s_axi_awready = !aw_held_ff;
   assign s_axi_wready = !w_held_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = !rvalid_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign link.cmd_valid = cmd_valid_ff;
   assign link.cmd_op = op_ff;
   assign link.cmd_p2 = qual_ff[7:0];
   assign link.cmd_p1 = qual_ff[15:8];
   assign link.cmd_lc = qual_ff[23:16];
   assign link.cmd_data = {data_ff[0], data_ff[1], data_ff[2], data_ff[3]};
endmodule

// >>> pve_chk.sv
`timescale 1ns/1ps
module pve_chk
   import pve_pkg::*;
#(
   parameter int NUM_PINS = 4
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Command link
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire pve_op_t cmd_op,
   input wire logic [7:0] cmd_p1,
   input wire logic [7:0] cmd_p2,
   input wire logic [7:0] cmd_lc,
   input wire logic [DATA_W-1:0] cmd_data,
   // Response link
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_sw
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic ref_bad;
   logic ref_ok;
   assign ref_bad = (cmd_p2[4:0] == 5'h00) || (32'(cmd_p2[4:0]) > NUM_PINS);
   assign ref_ok = !ref_bad && (cmd_p2[6:5] == 2'h0);

   sequence s_take;
      cmd_valid && cmd_ready;
   endsequence
   sequence s_ok_take;
      cmd_valid && cmd_ready && ref_ok && cmd_p1 == P1_NONE && cmd_op != OP_DISABLE;
   endsequence

   rsp_follows_a: assert property (s_take |=> rsp_valid)
      else $error("no answer after a taken command");
   rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid && cmd_ready))
      else $error("answer without a taken command");
   rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer valid longer than one cycle");
   sw_hold_a: assert property (!rsp_valid |-> $stable(rsp_sw))
      else $error("status word moved without an answer");
   req_hold_a: assert property (cmd_valid && !cmd_ready |=>
      cmd_valid && $stable(cmd_data) && $stable(cmd_p2))
      else $error("command dropped or changed before it was taken");
   empty_count_a: assert property (
      s_ok_take ##0 (cmd_op == OP_VERIFY && cmd_lc == LC_EMPTY) |=>
      rsp_sw[15:4] == 12'h63c && rsp_sw[3:0] <= 4'h3)
      else $error("empty verify did not report a retry count");
   bad_ref_a: assert property (s_take ##0 ref_bad |=> rsp_sw == SW_REF_NF)
      else $error("bad reference not refused");
   bad_p1_a: assert property (
      s_take ##0 (ref_ok && cmd_p1 != P1_NONE && cmd_op != OP_DISABLE) |=>
      rsp_sw == SW_BAD_P1P2)
      else $error("bad first parameter not refused");
   change_len_a: assert property (
      s_ok_take ##0 (cmd_op == OP_CHANGE && cmd_lc != LC_CHANGE) |=>
      rsp_sw == SW_WRONG_LEN)
      else $error("change with wrong length not refused");
endmodule

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   import pve_pkg::*;
   typedef struct {
      pve_op_t op;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] lc;
      logic [127:0] d;
      logic [15:0] sw;
   } pve_row_t;
   localparam pve_op_t V = OP_VERIFY;
   localparam pve_op_t C = OP_CHANGE;
   localparam pve_op_t D = OP_DISABLE;
   localparam logic [63:0] PA = PIN_RESET;
   localparam logic [63:0] PW = 64'h0102030405060708;
   localparam logic [63:0] PN = 64'h3132333435363738;
   logic aclk;
   logic aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic pin_release_valid, acc_valid, acc_done_ff, acc_grant_ff, se_revalidate_ff;
   logic [4:0] pin_release_ref;
   logic [63:0] pin_release_value;
   logic [3:0] acc_mask, pin_blocked_ff, pin_disabled_ff, pin_verified_ff;
   logic [7:0] key_usage_ff [4];
   int mismatches;
   int n_compared;
   int n_reval;
   pve_row_t rows [$];

   pve_link_if link();
   pve_terminal u_pve_terminal (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link);
   pve_card #(.NUM_PINS(4)) u_pve_card (.aclk, .aresetn, .link, .pin_release_valid,
      .pin_release_ref, .pin_release_value, .acc_valid, .acc_mask, .acc_done_ff,
      .acc_grant_ff, .pin_blocked_ff, .pin_disabled_ff, .pin_verified_ff,
      .key_usage_ff, .se_revalidate_ff);
   pve_chk #(.NUM_PINS(4)) u_pve_chk (.aclk, .aresetn, .cmd_valid(link.cmd_valid),
      .cmd_ready(link.cmd_ready), .cmd_op(link.cmd_op), .cmd_p1(link.cmd_p1),
      .cmd_p2(link.cmd_p2), .cmd_lc(link.cmd_lc), .cmd_data(link.cmd_data),
      .rsp_valid(link.rsp_valid), .rsp_sw(link.rsp_sw));

   initial begin
      aclk = 1'h0;
      forever #12.5 aclk = ~aclk;
   end

   always @(posedge aclk) if (se_revalidate_ff === 1'h1) n_reval <= n_reval + 1;

   task results;
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task timed_out;
      mismatches++;
      results;
   endtask

   // Both channels are offered together; each is released on its own handshake.
   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'h0;
            break;
         end
      end
      if (i == 100) timed_out;
   endtask

   task rd(input logic [7:0] a);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) begin
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
         end
      end
      if (i == 100) timed_out;
   endtask

   task run(input pve_row_t r);
      int i;
      wr(REG_DATA0, r.d[127:96]);
      wr(REG_DATA1, r.d[95:64]);
      wr(REG_DATA2, r.d[63:32]);
      wr(REG_DATA3, r.d[31:0]);
      wr(REG_QUAL, {8'h00, r.lc, r.p1, r.p2});
      wr(REG_CTRL, {29'h0, r.op, 1'h1});
      for (i = 0; i < 50; i++) begin
         rd(REG_STATUS);
         if (rd_data[1] === 1'h1) break;
      end
      if (i == 50) timed_out;
      check({16'h0, rd_data[31:16]}, {16'h0, r.sw});
   endtask

   task row(input pve_op_t op, input logic [7:0] p1, p2, lc, input logic [63:0] a, b,
      input logic [15:0] sw);
      rows.push_back('{op, p1, p2, lc, {a, b}, sw});
   endtask

   task acc(input logic [3:0] m, input logic g);
      @(posedge aclk);
      acc_valid <= 1'h1;
      acc_mask <= m;
      @(posedge aclk);
      acc_valid <= 1'h0;
      #1;
      check({31'h0, acc_done_ff}, 32'h1);
      check({31'h0, acc_grant_ff}, {31'h0, g});
   endtask

   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      {pin_release_valid, acc_valid, acc_mask, pin_release_ref} = 11'h0;
      pin_release_value = 64'h0;
      aresetn = 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      row(V, 8'h00, 8'h01, 8'h00, 64'h0, 64'h0, 16'h63c3);
      row(V, 8'h00, 8'h01, 8'h08, PW, 64'h0, 16'h63c2);
      row(V, 8'h00, 8'h01, 8'h00, 64'h0, 64'h0, 16'h63c2);
      row(V, 8'h00, 8'h01, 8'h08, PA, 64'h0, 16'h9000);
      row(V, 8'h00, 8'h01, 8'h00, 64'h0, 64'h0, 16'h63c3);
      row(V, 8'h00, 8'h01, 8'h08, PW, 64'h0, 16'h63c2);
      row(V, 8'h00, 8'h01, 8'h08, PW, 64'h0, 16'h63c1);
      row(V, 8'h00, 8'h01, 8'h08, PW, 64'h0, 16'h63c0);
      row(V, 8'h00, 8'h01, 8'h08, PA, 64'h0, 16'h6983);
      row(V, 8'h00, 8'h01, 8'h00, 64'h0, 64'h0, 16'h63c0);
      row(C, 8'h00, 8'h01, 8'h10, PA, PN, 16'h6983);
      row(D, 8'h00, 8'h01, 8'h08, PA, 64'h0, 16'h6983);
      row(C, 8'h00, 8'h02, 8'h10, PA, PN, 16'h9000);
      row(V, 8'h00, 8'h02, 8'h08, PA, 64'h0, 16'h63c2);
      row(C, 8'h00, 8'h02, 8'h10, PW, PA, 16'h63c1);
      row(V, 8'h00, 8'h02, 8'h08, PN, 64'h0, 16'h9000);
      row(V, 8'h00, 8'h82, 8'h00, 64'h0, 64'h0, 16'h63c3);
      row(D, 8'h00, 8'h03, 8'h08, PW, 64'h0, 16'h63c2);
      row(D, 8'h00, 8'h03, 8'h08, PA, 64'h0, 16'h9000);
      row(V, 8'h00, 8'h03, 8'h00, 64'h0, 64'h0, 16'h63c3);
      row(V, 8'h00, 8'h03, 8'h08, PA, 64'h0, 16'h6985);
      row(D, 8'h00, 8'h03, 8'h08, PA, 64'h0, 16'h6985);
      row(C, 8'h00, 8'h03, 8'h10, PA, PN, 16'h6985);
      row(D, 8'h81, 8'h04, 8'h08, PA, 64'h0, 16'h9000);
      row(V, 8'h00, 8'h00, 8'h00, 64'h0, 64'h0, 16'h6a88);
      row(V, 8'h00, 8'h05, 8'h00, 64'h0, 64'h0, 16'h6a88);
      row(V, 8'h01, 8'h02, 8'h00, 64'h0, 64'h0, 16'h6b00);
      row(V, 8'h00, 8'h02, 8'h04, 64'h0, 64'h0, 16'h6700);
      row(C, 8'h00, 8'h02, 8'h08, PN, 64'h0, 16'h6700);
      row(D, 8'h20, 8'h02, 8'h08, PN, 64'h0, 16'h6b00);
      row(D, 8'h80, 8'h02, 8'h08, PN, 64'h0, 16'h6b00);
      row(D, 8'h01, 8'h02, 8'h08, PN, 64'h0, 16'h6b00);
      row(V, 8'h00, 8'h02, 8'h00, 64'h0, 64'h0, 16'h63c3);
      foreach (rows[k]) run(rows[k]);
      check({28'h0, pin_blocked_ff}, 32'h1);
      check({28'h0, pin_disabled_ff}, 32'hc);
      check({24'h0, key_usage_ff[0]}, 32'h8);
      check(n_reval, 32'h2);
      check({28'h0, pin_verified_ff}, 32'h2);
      rd(REG_QUAL);
      check(rd_data, 32'h00000002);
      acc(4'h1, 1'h0);
      acc(4'h2, 1'h1);
      acc(4'h4, 1'h1);
      acc(4'h8, 1'h0);
      acc(4'h9, 1'h1);
      acc(4'h0, 1'h1);
      @(posedge aclk);
      pin_release_valid <= 1'h1;
      pin_release_ref <= 5'h01;
      pin_release_value <= PA;
      @(posedge aclk);
      pin_release_valid <= 1'h0;
      acc(4'h1, 1'h1);
      acc(4'h8, 1'h1);
      rd(8'h40);
      check({30'h0, rd_resp}, {30'h0, AXI_SLVERR});
      check(rd_data, 32'h0);
      // A second reset in mid-run must clear the status register and the verified flag of PIN 2, and set the retry count of PIN 1 back to three.
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      rd(REG_STATUS);
      check(rd_data, 32'h0);
      acc(4'h2, 1'h0);
      run('{V, 8'h00, 8'h01, 8'h00, 128'h0, 16'h63c3});
      results;
   end
endmodule
